// >>> tbt_pkg.sv
// package for the 10BASE-T control/status register block
// assumes a 32-bit apb slave port and one 250 MHz clock domain
package tbt_pkg;

	// ========================================================
	// register map, apb byte addresses
	// ========================================================
	// printed offset is an index, so the byte address is four times it
	localparam logic [7:0] CSR_IDX = 8'h1A;
	localparam logic [7:0] CSR_ADDR = {CSR_IDX[5:0], 2'b00};
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h70;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h74;

	// ========================================================
	// field positions of the control/status word
	// ========================================================
	localparam int BIT_TOP = 15;
	localparam int RSV_HI = 14;
	localparam int RSV_LO = 12;
	localparam int SQ_HI = 11;
	localparam int SQ_LO = 9;
	localparam int BIT_LOOP = 8;
	localparam int BIT_LP = 7;
	localparam int BIT_FLINK = 6;
	localparam int BIT_FPOL = 5;
	localparam int BIT_POLST = 4;
	localparam int BIT_APOL = 3;
	localparam int BIT_SCALE = 2;
	localparam int BIT_HB = 1;
	localparam int BIT_JAB = 0;

	// squelch 3'b100 at 11:9, scale bit at 2
	localparam logic [15:0] CSR_RST = 16'h0804;
	// writable bits: all but the top bit and the polarity status
	localparam logic [15:0] CSR_WMASK = 16'h7FEF;

	// ========================================================
	// interrupt events
	// ========================================================
	localparam int EV_N = 2;
	localparam int EV_POL = 0;
	localparam int EV_XLINK = 1;
	localparam logic [EV_N-1:0] IRQ_RST = 2'h0;

	// ========================================================
	// carriers
	// ========================================================
	// levels from the neighbouring phy logic, same clock
	typedef struct packed {
		logic basic_control_reg_loopback;
		logic sd_scale_lo;
		logic phy_status_rd;
		logic speed_100;
		logic full_duplex;
		logic link_detect_ok;
		logic rx_pol_reversed;
	} tbt_nbr_t;

	// controls toward the 10BASE-T receive and transmit paths
	typedef struct packed {
		logic [2:0] squelch_level;
		logic loop10_off;
		logic nlp_tx_off;
		logic link10_good;
		logic pol_invert;
		logic pol_status;
		logic [1:0] silence_scale;
		logic heartbeat_en;
		logic jabber_en;
	} tbt_ctl_t;

endpackage

// >>> tbt_irq.sv
// sticky interrupt status with mask, write one to clear
// assumes events are one-cycle pulses on the block clock
`timescale 1ns/1ps
`default_nettype none
module tbt_irq #(
	parameter int N = 2
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// event pulses
	input wire logic [N-1:0] ev,
	// software access
	input wire logic stat_wr,
	input wire logic mask_wr,
	input wire logic [N-1:0] wdata,
	// state
	output logic [N-1:0] stat_q,
	output logic [N-1:0] mask_q,
	output logic irq
);

	// ========================================================
	// sticky status
	// ========================================================
	// set beats clear so a coincident event is not lost
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stat_q <= N'(0);
		end else if (ce) begin
			stat_q <= (stat_q & ~(stat_wr ? wdata : N'(0))) | ev;
		end
	end

	// ========================================================
	// mask
	// ========================================================
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mask_q <= N'(0);
		end else if (ce && mask_wr) begin
			mask_q <= wdata;
		end
	end

	// level output, high while any unmasked bit stands
	assign irq = |(stat_q & mask_q);

endmodule
`default_nettype wire

// >>> tbt_csr.sv
// 10BASE-T control/status register with apb slave and interrupts
// assumes apb master on clk, neighbour levels on clk, force pin async
`timescale 1ns/1ps
`default_nettype none
module tbt_csr (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// neighbouring phy logic and pin
	input wire tbt_pkg::tbt_nbr_t nbr,
	input wire logic external_good_link_override,
	// controls and interrupt
	output tbt_pkg::tbt_ctl_t ctl,
	output logic irq
);

	// ========================================================
	// declarations
	// ========================================================
	logic [15:0] csr_q; // stored word, status bit held apart
	logic pol_latch_q; // latched-high inverted polarity
	logic [31:0] rdata_q; // read data captured at setup
	logic err_q; // unmapped address seen at setup
	logic ack_q; // setup seen, answer ready
	logic xl_s1_q, xl_s2_q, xl_s3_q; // force pin synchroniser
	logic xlink_q; // filtered force pin level
	tbt_pkg::tbt_ctl_t ctl_q; // registered control outputs
	logic setup, access, wr_acc, rd_acc;
	logic csr_wr, stat_wr, mask_wr;
	logic pol_set, pol_clr, xlink_rise;
	logic [tbt_pkg::EV_N-1:0] ev, stat, mask;
	logic [15:0] csr_view;

	// address compare, used by every decode below
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		hit = (a == t);
	endfunction

	// ========================================================
	// apb phases
	// ========================================================
	// taken at the first enabled edge with no answer pending, so a
	// setup cycle that a low ce froze is still caught in the access
	assign setup = psel && !ack_q;
	assign access = psel && penable && ack_q && ce;
	assign wr_acc = access && pwrite;
	assign rd_acc = access && !pwrite;
	assign csr_wr = wr_acc && hit(paddr, tbt_pkg::CSR_ADDR);
	assign stat_wr = wr_acc && hit(paddr, tbt_pkg::IRQ_STAT_ADDR);
	assign mask_wr = wr_acc && hit(paddr, tbt_pkg::IRQ_MASK_ADDR);

	// no wait state while ce is high: answer in the access cycle after a setup
	assign pready = ack_q && ce;
	assign pslverr = pready && err_q;
	assign prdata = rdata_q;

	// readable view, top bit forced low
	always_comb begin
		csr_view = csr_q;
		csr_view[tbt_pkg::BIT_TOP] = 1'b0;
		csr_view[tbt_pkg::BIT_POLST] = pol_latch_q;
	end

	// ========================================================
	// apb answer
	// ========================================================
	// data captured at setup so the output comes from flops
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			ack_q <= 1'b0;
		end else if (ce) begin
			if (setup) begin
				ack_q <= 1'b1;
				err_q <= 1'b0;
				rdata_q <= 32'h0000_0000;
				if (hit(paddr, tbt_pkg::CSR_ADDR)) begin
					rdata_q <= {16'h0000, csr_view};
				end else if (hit(paddr, tbt_pkg::IRQ_STAT_ADDR)) begin
					rdata_q <= {30'h0000_0000, stat};
				end else if (hit(paddr, tbt_pkg::IRQ_MASK_ADDR)) begin
					rdata_q <= {30'h0000_0000, mask};
				end else begin
					// unmapped: error answer, zero data
					err_q <= 1'b1;
				end
			end else if (access) begin
				ack_q <= 1'b0;
			end
		end
	end

	// ========================================================
	// control/status word
	// ========================================================
	// byte lanes honoured; read-only bits keep their value
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			csr_q <= tbt_pkg::CSR_RST;
		end else if (ce && csr_wr) begin
			for (int i = 0; i < 16; i++) begin
				if (pstrb[i/8] && tbt_pkg::CSR_WMASK[i]) begin
					csr_q[i] <= pwdata[i];
				end
			end
		end
	end

	// ========================================================
	// polarity status latch
	// ========================================================
	// detection only while auto polarity is on
	assign pol_set = nbr.rx_pol_reversed && !csr_q[tbt_pkg::BIT_APOL];
	// clear only what the read reported, so a later event survives
	assign pol_clr = (rd_acc && hit(paddr, tbt_pkg::CSR_ADDR) &&
		rdata_q[tbt_pkg::BIT_POLST]) || nbr.phy_status_rd;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pol_latch_q <= 1'b0;
		end else if (ce) begin
			// set wins over clear
			if (pol_set) begin
				pol_latch_q <= 1'b1;
			end else if (pol_clr) begin
				pol_latch_q <= 1'b0;
			end
		end
	end

	// ========================================================
	// force-link pin synchroniser
	// ========================================================
	// level changes only once the second and third stages agree
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			xl_s1_q <= 1'b0;
			xl_s2_q <= 1'b0;
			xl_s3_q <= 1'b0;
			xlink_q <= 1'b0;
		end else if (ce) begin
			xl_s1_q <= external_good_link_override;
			xl_s2_q <= xl_s1_q;
			xl_s3_q <= xl_s2_q;
			if (xl_s2_q == xl_s3_q) begin
				xlink_q <= xl_s3_q;
			end
		end
	end

	assign xlink_rise = xl_s2_q && xl_s3_q && !xlink_q;

	// ========================================================
	// controls toward the 10BASE-T paths
	// ========================================================
	// registered so the receiver never sees a decode glitch
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl_q <= '0;
		end else if (ce) begin
			ctl_q.squelch_level <= csr_q[tbt_pkg::SQ_HI:tbt_pkg::SQ_LO];
			ctl_q.loop10_off <= csr_q[tbt_pkg::BIT_LOOP] |
				nbr.basic_control_reg_loopback;
			ctl_q.nlp_tx_off <= csr_q[tbt_pkg::BIT_LP] | xlink_q;
			ctl_q.link10_good <= csr_q[tbt_pkg::BIT_FLINK] | xlink_q |
				nbr.link_detect_ok;
			// override forces inversion; else auto correction if enabled
			ctl_q.pol_invert <= csr_q[tbt_pkg::BIT_FPOL] |
				(!csr_q[tbt_pkg::BIT_APOL] & nbr.rx_pol_reversed);
			ctl_q.pol_status <= pol_latch_q;
			ctl_q.silence_scale <= {csr_q[tbt_pkg::BIT_SCALE],
				nbr.sd_scale_lo};
			// heartbeat off at 100 Mb or full duplex whatever the bit
			ctl_q.heartbeat_en <= !nbr.speed_100 && !nbr.full_duplex &&
				!csr_q[tbt_pkg::BIT_HB];
			// jabber guard: only meaningful at 10 Mb; keep it off for
			// continuous test patterns by setting the jabber bit first
			ctl_q.jabber_en <= !nbr.speed_100 &&
				!csr_q[tbt_pkg::BIT_JAB];
		end
	end

	assign ctl = ctl_q;

	// ========================================================
	// interrupts
	// ========================================================
	always_comb begin
		ev = '0;
		ev[tbt_pkg::EV_POL] = ce && pol_set && !pol_latch_q;
		ev[tbt_pkg::EV_XLINK] = ce && xlink_rise;
	end

	tbt_irq #(
		.N(tbt_pkg::EV_N)
	) u_irq (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.ev(ev),
		.stat_wr(stat_wr && pstrb[0]),
		.mask_wr(mask_wr && pstrb[0]),
		.wdata(pwdata[tbt_pkg::EV_N-1:0]),
		.stat_q(stat),
		.mask_q(mask),
		.irq(irq)
	);

	// ========================================================
	// assertions
	// ========================================================
	// run_q lags reset by one edge: checks wake only once the
	// release edge has passed and the outputs left their reset values
	logic run_q;
	always_ff @(posedge clk) begin
		run_q <= rst_b;
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b || !run_q);

	// top bit always reads zero
	rsv_top_zero_a: assert property (
		(pready && !pwrite && hit(paddr, tbt_pkg::CSR_ADDR)) |->
		!prdata[tbt_pkg::BIT_TOP])
		else $error("top bit read back as one");

	// squelch output follows the stored field one cycle later
	squelch_out_a: assert property (
		ce |=> ctl.squelch_level ==
		$past(csr_q[tbt_pkg::SQ_HI:tbt_pkg::SQ_LO]))
		else $error("squelch level not passed on");

	// loopback disable is the or of both sources
	loop_or_a: assert property (
		ce |=> ctl.loop10_off == ($past(csr_q[tbt_pkg::BIT_LOOP]) |
		$past(nbr.basic_control_reg_loopback)))
		else $error("loopback disable not ored");

	// link pulses stop under bit or external force
	nlp_stop_a: assert property (
		(ce && (csr_q[tbt_pkg::BIT_LP] || xlink_q)) |=> ctl.nlp_tx_off)
		else $error("link pulses not stopped");

	// forced link bit shows good the cycle after an enabled edge with it set
	force_link_a: assert property (
		(ce && csr_q[tbt_pkg::BIT_FLINK]) |=> ctl.link10_good)
		else $error("forced link not reported good");

	// polarity override inverts
	pol_force_a: assert property (
		(ce && csr_q[tbt_pkg::BIT_FPOL]) |=> ctl.pol_invert)
		else $error("polarity override ignored");

	// a status-register read clears the latch unless a new event
	pol_clear_a: assert property (
		(ce && nbr.phy_status_rd && !pol_set) |=> !pol_latch_q)
		else $error("polarity latch not cleared by read");

	// auto polarity off: latch never rises, no correction
	autopol_off_a: assert property (
		(ce && csr_q[tbt_pkg::BIT_APOL] && !pol_latch_q) |=>
		!pol_latch_q)
		else $error("polarity detected while auto disabled");

	// scale bit defaults to one after reset
	scale_rst_a: assert property (
		$past(!rst_b) |-> csr_q[tbt_pkg::BIT_SCALE] &&
		csr_q[tbt_pkg::SQ_HI:tbt_pkg::SQ_LO] == 3'h4)
		else $error("reset defaults wrong");

	// heartbeat off at 100 Mb or full duplex
	hb_gate_a: assert property (
		(ce && (nbr.speed_100 || nbr.full_duplex)) |=> !ctl.heartbeat_en)
		else $error("heartbeat on outside half-duplex 10 Mb");

	// jabber bit turns jabber off
	jab_gate_a: assert property (
		(ce && csr_q[tbt_pkg::BIT_JAB]) |=> !ctl.jabber_en)
		else $error("jabber not disabled");

	// a full-lane write of a writable field reads back
	rw_back_a: assert property (
		(csr_wr && pstrb == 4'hF) |=>
		csr_q[tbt_pkg::SQ_HI:tbt_pkg::SQ_LO] ==
		$past(pwdata[tbt_pkg::SQ_HI:tbt_pkg::SQ_LO]))
		else $error("written field not stored");

	// main scenarios
	csr_write_c: cover property (csr_wr);
	pol_event_c: cover property (pol_set && !pol_latch_q ##[1:20] pol_clr);
	irq_rise_c: cover property ($rose(irq));
	unmapped_c: cover property (pslverr);

endmodule
`default_nettype wire

// >>> tenbase_t_control_status_reg_tb.sv
// self-checking bench for the 10BASE-T control/status register block
// assumes tbt_pkg is compiled first and tbt_csr is the design top
`timescale 1ns/1ps
`default_nettype none
module tenbase_t_control_status_reg_tb;
	// ==================================================
	// signals
	// ==================================================
	logic clk;
	logic rst_b;
	logic ce;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tbt_pkg::tbt_nbr_t nbr;
	logic pin; // force-link pin, async to the design
	tbt_pkg::tbt_ctl_t ctl;
	logic irq;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rng; // xorshift state
	logic [31:0] rd; // last read data
	logic [31:0] wd;
	logic err; // last error flag
	logic ce_mix; // ce runs at half rate while set

	tbt_csr tbt_csr_i (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.nbr(nbr),
		.external_good_link_override(pin),
		.ctl(ctl),
		.irq(irq)
	);

	// 4 ns clock
	always #2 clk = ~clk;

	// half-rate enable exercises the freeze and late setup capture
	always @(posedge clk) begin
		ce <= ce_mix ? !ce : 1'b1;
	end

	// ==================================================
	// helpers
	// ==================================================
	// fixed seed keeps every run identical
	function automatic logic [31:0] xorshift();
		logic [31:0] s;
		s = rng;
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		rng = s;
		return s;
	endfunction

	// expected controls from a register word and the neighbour levels
	function automatic logic [11:0] exp_ctl(input logic [15:0] r);
		return {r[11:9], r[8] | nbr.basic_control_reg_loopback, r[7] | pin,
			r[6] | pin | nbr.link_detect_ok,
			r[5] | (!r[3] & nbr.rx_pol_reversed), 1'b0,
			r[2], nbr.sd_scale_lo,
			!nbr.speed_100 & !nbr.full_duplex & !r[1],
			!nbr.speed_100 & !r[0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready, the hang guard bounds it
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// reversed polarity seen for two cycles, then gone
	task automatic pol_pulse(input logic exp_inv);
		nbr.rx_pol_reversed <= 1'b1;
		repeat (2) @(posedge clk);
		chk(ctl.pol_invert, exp_inv);
		nbr.rx_pol_reversed <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run;
		end
	end

	// ==================================================
	// main sequence
	// ==================================================
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		ce_mix = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		nbr = '0;
		pin = 1'b0;
		rng = 32'h30ADD05B;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		// defaults after reset
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd, 32'h0000_0804);
		chk({20'h0, ctl}, {20'h0, exp_ctl(16'h0804)});
		apb(1'b1, tbt_pkg::IRQ_MASK_ADDR, 32'h3);
		// all-ones and all-zeros corners first, then random words
		for (int i = 0; i < 40; i++) begin
			wd = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : xorshift();
			// second half of the loop runs with a toggling enable
			ce_mix <= (i >= 20);
			// no polarity event or status read in this loop
			nbr <= tbt_pkg::tbt_nbr_t'(7'(xorshift() & 32'h6E));
			apb(1'b1, tbt_pkg::CSR_ADDR, wd);
			apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
			chk(rd, {16'h0, wd[15:0] & 16'h7FEF});
			chk({20'h0, ctl}, {20'h0, exp_ctl(wd[15:0])});
		end
		// polarity latch, cleared by a register read
		ce_mix <= 1'b0;
		nbr <= '0;
		apb(1'b1, tbt_pkg::CSR_ADDR, 32'h0);
		pol_pulse(1'b1);
		chk(ctl.pol_status, 1'b1);
		chk(irq, 1'b1);
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd[4], 1'b1);
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd[4], 1'b0);
		apb(1'b0, tbt_pkg::IRQ_STAT_ADDR, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, tbt_pkg::IRQ_STAT_ADDR, 32'h1);
		@(posedge clk);
		chk(irq, 1'b0);
		// masked event, latch cleared by the neighbour status read
		apb(1'b1, tbt_pkg::IRQ_MASK_ADDR, 32'h0);
		pol_pulse(1'b1);
		chk(irq, 1'b0);
		nbr.phy_status_rd <= 1'b1;
		@(posedge clk);
		nbr.phy_status_rd <= 1'b0;
		repeat (2) @(posedge clk);
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd[4], 1'b0);
		apb(1'b0, tbt_pkg::IRQ_STAT_ADDR, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, tbt_pkg::IRQ_STAT_ADDR, 32'h1);
		apb(1'b1, tbt_pkg::IRQ_MASK_ADDR, 32'h3);
		// auto polarity off: no correction, no detection
		apb(1'b1, tbt_pkg::CSR_ADDR, 32'h8);
		pol_pulse(1'b0);
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd, 32'h8);
		// force-link pin forces link and stops link pulses
		pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(ctl.link10_good, 1'b1);
		chk(ctl.nlp_tx_off, 1'b1);
		chk(irq, 1'b1);
		apb(1'b0, tbt_pkg::IRQ_STAT_ADDR, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, tbt_pkg::IRQ_STAT_ADDR, 32'h2);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		chk(irq, 1'b0);
		chk({20'h0, ctl}, {20'h0, exp_ctl(16'h8)});
		// unmapped address is refused, its write dropped
		apb(1'b0, 8'h00, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h00, 32'hFFFF);
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(err, 1'b0);
		chk(rd, 32'h8);
		// low byte lane alone: the upper byte keeps its value
		pstrb <= 4'h1;
		apb(1'b1, tbt_pkg::CSR_ADDR, 32'hFFFF);
		pstrb <= 4'hF;
		apb(1'b0, tbt_pkg::CSR_ADDR, 32'h0);
		chk(rd, 32'hEF);
		// jabber off ahead of a continuous test at 10 Mb
		nbr <= '0;
		apb(1'b1, tbt_pkg::CSR_ADDR, 32'h1);
		repeat (2) @(posedge clk);
		chk(ctl.jabber_en, 1'b0);
		complete_run;
	end
endmodule
`default_nettype wire
